// File: bbp_pkg.sv
// What this block does
// [RULE1] carry sits in status bit 7, set by arithmetic and by software writes
// [RULE2] half carry follows carry or borrow out of bit 3 on add or subtract
// [RULE3] status bit 5 is a user flag, hardware never changes it
// [RULE4] two bank bits pick one of four eight-byte register banks
// [RULE5] overflow bit is set or cleared by arithmetic signed overflow
// [RULE6] parity bit refreshed every cycle for even parity with the accumulator
// [RULE7] port three bits 7 and 6 pulse low for external reads and writes
// [RULE8] edge flags set on detected falling edge, cleared when serviced
// [RULE9] type bit set selects falling edge, cleared selects low level
// [RULE10] timer wrap flags set on overflow, cleared when serviced
// [RULE11] timer run bits start and stop their timers
// [RULE12] with filter set, frames whose ninth bit is zero are discarded
// [RULE13] receive enable bit gates serial reception
// [RULE14] transmit ninth bit supplies the ninth data bit in nine-bit mode
// [RULE15] global enable cleared blocks every interrupt
// [RULE16] five enable bits gate serial, timer 1, pin 1, timer 0, pin 0
// [RULE17] five priority bits give high priority when set
// [RULE18] software keeps away from unimplemented addresses and reserved bits
// [RULE19] set, clear, invert any bit or the carry in one instruction cycle
// [RULE20] bit to carry takes one cycle, carry to bit takes two
// [RULE21] and/or combine carry with bit or its inverse, source untouched
// [RULE22] byte writes to the status word also change the carry
// [RULE23] bit addresses 0 to 127 select bits of the 16-byte bit RAM
// [RULE24] bit addresses 128 to 255 select register bits by address and position
// [RULE25] reserved status, enable and priority bits hold nothing, read zero
package bbp_pkg;
	localparam logic [7:0] PSW_ADDR = 8'hD0;
	localparam logic [7:0] P3_ADDR = 8'hB0;
	localparam logic [7:0] TIMER_CONTROL_ADDR = 8'h88;
	localparam logic [7:0] SERIAL_CONTROL_ADDR = 8'h98;
	localparam logic [7:0] IE_ADDR = 8'hA8;
	localparam logic [7:0] IP_ADDR = 8'hB8;
	localparam int PSW_CARRY = 7;
	localparam int PSW_HALF = 6;
	localparam int PSW_USER = 5;
	localparam int PSW_BANK_LO = 3;
	localparam int PSW_RANGE = 2;
	localparam int PSW_PARITY = 0;
	localparam int TIMER_CONTROL_TF1 = 7;
	localparam int TIMER_CONTROL_TF0 = 5;
	localparam int TIMER_CONTROL_TR0 = 4;
	localparam int TIMER_CONTROL_IE1 = 3;
	localparam int TIMER_CONTROL_IT1 = 2;
	localparam int TIMER_CONTROL_IE0 = 1;
	localparam int TIMER_CONTROL_IT0 = 0;
	localparam int IE_GLOBAL = 7;
	localparam int P3_RD_STROBE = 7;
	localparam int P3_WR_STROBE = 6;
	localparam logic [7:0] PSW_IMPL = 8'hFD;
	localparam logic [7:0] IE_IMPL = 8'h9F;
	localparam logic [7:0] IP_IMPL = 8'h1F;
	localparam logic [7:0] PSW_RESET = 8'h00;
	localparam logic [7:0] P3_RESET = 8'hFF;
	localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
	localparam logic [7:0] SERIAL_CONTROL_RESET = 8'h00;
	localparam logic [7:0] IE_RESET = 8'h00;
	localparam logic [7:0] IP_RESET = 8'h00;
	localparam int SRC_EXT0 = 0;
	localparam int SRC_T0 = 1;
	localparam int SRC_EXT1 = 2;
	localparam int SRC_T1 = 3;
	localparam int INSTR_CLKS = 2;
	localparam logic [1:0] STALL_LAST = 2'(INSTR_CLKS - 1);

	typedef enum logic [3:0] {
		bbp_no_op = 4'h0,
		bbp_carry_set_op = 4'h1,
		bbp_carry_clear_op = 4'h2,
		bbp_carry_invert_op = 4'h3,
		bbp_bit_set_op = 4'h4,
		bbp_bit_clear_op = 4'h5,
		bbp_bit_invert_op = 4'h6,
		bbp_bit_copy_op = 4'h7,
		bbp_carry_copy_op = 4'h8,
		bbp_carry_and_op = 4'h9,
		bbp_carry_and_not_op = 4'hA,
		bbp_carry_or_op = 4'hB,
		bbp_carry_or_not_op = 4'hC
	} bbp_op_type;

	typedef enum logic [1:0] {
		bbp_idle = 2'h0,
		bbp_fetch = 2'h1,
		bbp_stall = 2'h3,
		bbp_commit = 2'h2
	} bbp_state_type;

	typedef enum logic [2:0] {
		bbp_sfr_none, bbp_sfr_psw, bbp_sfr_p3, bbp_sfr_timer_control,
		bbp_sfr_serial_control, bbp_sfr_ie, bbp_sfr_ip
	} bbp_sfr_type;

	typedef struct packed {
		bbp_op_type op;
		logic [7:0] addr;
	} bbp_req_type;

	typedef struct packed {
		logic valid;
		logic upd_aux;
		logic carry;
		logic half_carry;
		logic range_err;
	} bbp_arith_type;

	typedef struct packed {
		logic serial_mode_bit_a;
		logic serial_mode_bit_b;
		logic multiproc_filter_bit;
		logic rx_enable;
		logic tx_ninth_bit;
		logic rx_ninth_bit;
		logic tx_done_flag;
		logic rx_done_flag;
	} bbp_serial_ctl_type;

	typedef struct packed {
		logic [4:0] req;
		logic [4:0] high;
	} bbp_irq_type;
endpackage

// File: bbp_bit_ram.sv
`timescale 1ns/1ps
module bbp_bit_ram (
	input wire logic i_clk_sys, // core clock
	input wire logic i_rst, // async reset, high
	input wire logic i_wr_en, // write one bit
	input wire logic [6:0] i_wr_addr, // bit to write
	input wire logic i_wr_data, // value written
	input wire logic [6:0] i_rd_addr, // bit to read
	output logic o_rd_data // registered read bit
);
	logic [127:0] bits;

	// bit n lives in byte n/8, position n%8, so a flat vector matches
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			bits <= 128'h0;
			o_rd_data <= 1'b0;
		end else begin
			if (i_wr_en)
				bits[i_wr_addr] <= i_wr_data; // [RULE23]
			o_rd_data <= bits[i_rd_addr];
		end
	end
endmodule

// File: bbp_core.sv
`timescale 1ns/1ps
module bbp_core (
	input wire logic i_clk_sys, // 20 MHz core clock
	input wire logic i_rst, // async reset, high
	input wire logic i_req_valid, // bit operation request
	input wire bbp_pkg::bbp_req_type i_req, // operation and bit address
	output logic o_busy, // operation in progress
	output logic o_done, // one-cycle completion pulse
	output logic o_bit_value, // result of last operation
	input wire bbp_pkg::bbp_arith_type i_arith, // flags from the byte alu
	input wire logic [7:0] i_acc, // accumulator for parity
	input wire logic i_sfr_wr, // byte register write
	input wire logic i_sfr_rd, // byte register read
	input wire logic [7:0] i_sfr_addr, // byte register address
	input wire logic [7:0] i_sfr_wdata, // byte write data
	output logic [7:0] o_sfr_rdata, // byte read data
	input wire logic [1:0] i_timer_wrap, // timer overflow pulses
	input wire logic [1:0] i_ext_irq_pins, // external interrupt pins
	input wire logic [4:0] i_irq_ack, // interrupt serviced, one-hot
	input wire logic i_tx_done, // serial transmit finished
	input wire logic i_rx_frame, // serial frame received
	input wire logic i_rx_ninth, // ninth bit of that frame
	output logic o_rx_accept, // frame accepted pulse
	input wire logic i_xmem_rd, // external data read cycle
	input wire logic i_xmem_wr, // external data write cycle
	input wire logic [7:0] i_port3_pins, // port three pin levels
	output logic [7:0] o_port3, // port three drive levels
	output logic [7:0] o_status_word, // status word
	output logic [7:0] o_bank_base, // working register bank base
	output logic [1:0] o_timer_run, // timer run controls
	output bbp_pkg::bbp_serial_ctl_type o_serial_ctl, // serial control
	output bbp_pkg::bbp_irq_type o_irq // gated requests, priority
);
	////////////////////////////////////////////////////////////////
	function automatic bbp_pkg::bbp_sfr_type sfr_of(input logic [7:0] a);
		case (a)
			bbp_pkg::PSW_ADDR: return bbp_pkg::bbp_sfr_psw;
			bbp_pkg::P3_ADDR: return bbp_pkg::bbp_sfr_p3;
			bbp_pkg::TIMER_CONTROL_ADDR: return bbp_pkg::bbp_sfr_timer_control;
			bbp_pkg::SERIAL_CONTROL_ADDR: return bbp_pkg::bbp_sfr_serial_control;
			bbp_pkg::IE_ADDR: return bbp_pkg::bbp_sfr_ie;
			bbp_pkg::IP_ADDR: return bbp_pkg::bbp_sfr_ip;
			default: return bbp_pkg::bbp_sfr_none;
		endcase
	endfunction

	function automatic logic [7:0] sfr_value(
		input bbp_pkg::bbp_sfr_type s,
		input logic [7:0] psw_v,
		input logic [7:0] p3_v,
		input logic [7:0] timer_control_v,
		input logic [7:0] serial_control_v,
		input logic [7:0] ie_v,
		input logic [7:0] ip_v
	);
		case (s)
			bbp_pkg::bbp_sfr_psw: return psw_v;
			bbp_pkg::bbp_sfr_p3: return p3_v;
			bbp_pkg::bbp_sfr_timer_control: return timer_control_v;
			bbp_pkg::bbp_sfr_serial_control: return serial_control_v;
			bbp_pkg::bbp_sfr_ie: return ie_v;
			bbp_pkg::bbp_sfr_ip: return ip_v;
			default: return 8'h00;
		endcase
	endfunction

	function automatic logic [7:0] merge(input logic [7:0] old,
		input logic hit, input logic [7:0] mask, input logic [7:0] data);
		return hit ? ((old & ~mask) | (data & mask)) : old;
	endfunction

	////////////////////////////////////////////////////////////////
	bbp_pkg::bbp_state_type state;
	bbp_pkg::bbp_state_type next_state;
	bbp_pkg::bbp_req_type cur;
	logic [1:0] stall_cnt;
	logic operand;
	logic [7:0] program_status_word;
	logic [7:0] p3_latch;
	logic [7:0] timer_control;
	bbp_pkg::bbp_serial_ctl_type serial_control;
	logic [7:0] ie;
	logic [7:0] ip;
	logic [1:0] pin_q;
	logic ram_q;

	wire take = (state == bbp_pkg::bbp_idle) && i_req_valid;
	wire cur_ram = !cur.addr[7]; // [RULE23]
	wire bbp_pkg::bbp_sfr_type cur_sfr = sfr_of({cur.addr[7:3], 3'h0}); // [RULE24]
	wire [7:0] cur_mask = 8'h01 << cur.addr[2:0];
	wire [7:0] cur_byte = sfr_value(cur_sfr, program_status_word, p3_latch, timer_control, serial_control,
		ie, ip);
	wire sfr_bit = |(cur_byte & cur_mask);
	wire carry = program_status_word[bbp_pkg::PSW_CARRY];
	// four-clock class: carry to bit and the and/or forms
	wire cur_long = (cur.op == bbp_pkg::bbp_carry_copy_op) ||
		(cur.op == bbp_pkg::bbp_carry_and_op) ||
		(cur.op == bbp_pkg::bbp_carry_and_not_op) ||
		(cur.op == bbp_pkg::bbp_carry_or_op) ||
		(cur.op == bbp_pkg::bbp_carry_or_not_op); // [RULE20]

	////////////////////////////////////////////////////////////////
	// operation result and its destination
	logic result;
	logic to_carry;
	always_comb begin
		result = 1'b0;
		to_carry = 1'b1;
		case (cur.op)
			bbp_pkg::bbp_carry_set_op: result = 1'b1; // [RULE19]
			bbp_pkg::bbp_carry_clear_op: result = 1'b0;
			bbp_pkg::bbp_carry_invert_op: result = !carry;
			bbp_pkg::bbp_bit_copy_op: result = operand; // [RULE20]
			// source bit is only read, never written back
			bbp_pkg::bbp_carry_and_op: result = carry & operand; // [RULE21]
			bbp_pkg::bbp_carry_and_not_op: result = carry & !operand;
			bbp_pkg::bbp_carry_or_op: result = carry | operand;
			bbp_pkg::bbp_carry_or_not_op: result = carry | !operand;
			bbp_pkg::bbp_bit_set_op: begin
				result = 1'b1; // [RULE19]
				to_carry = 1'b0;
			end
			bbp_pkg::bbp_bit_clear_op: begin
				result = 1'b0;
				to_carry = 1'b0;
			end
			bbp_pkg::bbp_bit_invert_op: begin
				result = !operand;
				to_carry = 1'b0;
			end
			bbp_pkg::bbp_carry_copy_op: begin
				result = carry; // [RULE20]
				to_carry = 1'b0;
			end
			default: to_carry = 1'b0;
		endcase
	end

	wire commit = (state == bbp_pkg::bbp_commit) &&
		(cur.op != bbp_pkg::bbp_no_op);
	wire ram_wr = commit && !to_carry && cur_ram;
	// bit writes to registers share the byte write port, masked to one bit
	wire w_bit = commit && (to_carry || !cur_ram);
	wire w_en = w_bit || i_sfr_wr;
	wire bbp_pkg::bbp_sfr_type w_sfr = !w_bit ? sfr_of(i_sfr_addr) :
		to_carry ? bbp_pkg::bbp_sfr_psw : cur_sfr;
	wire [7:0] w_mask = !w_bit ? 8'hFF :
		to_carry ? (8'h01 << bbp_pkg::PSW_CARRY) : cur_mask;
	wire [7:0] w_data = w_bit ? {8{result}} : i_sfr_wdata;
	wire hit_psw = w_en && (w_sfr == bbp_pkg::bbp_sfr_psw);
	wire hit_p3 = w_en && (w_sfr == bbp_pkg::bbp_sfr_p3);
	wire hit_timer_control = w_en && (w_sfr == bbp_pkg::bbp_sfr_timer_control);
	wire hit_serial_control = w_en && (w_sfr == bbp_pkg::bbp_sfr_serial_control);
	wire hit_ie = w_en && (w_sfr == bbp_pkg::bbp_sfr_ie);
	wire hit_ip = w_en && (w_sfr == bbp_pkg::bbp_sfr_ip);

	////////////////////////////////////////////////////////////////
	// status word: arithmetic first, then software or bit writes on top
	logic [7:0] psw_arith;
	always_comb begin
		psw_arith = program_status_word;
		if (i_arith.valid) begin
			psw_arith[bbp_pkg::PSW_CARRY] = i_arith.carry; // [RULE1]
			if (i_arith.upd_aux) begin
				psw_arith[bbp_pkg::PSW_HALF] = i_arith.half_carry; // [RULE2]
				psw_arith[bbp_pkg::PSW_RANGE] = i_arith.range_err; // [RULE5]
			end
		end
	end
	// byte writes land on the carry too; parity is never software owned
	wire [7:0] psw_w = merge(psw_arith, hit_psw, w_mask, w_data); // [RULE22]
	wire [7:0] next_psw = {psw_w[7:2] & bbp_pkg::PSW_IMPL[7:2], 1'b0,
		^i_acc}; // [RULE6] [RULE25]
	wire [7:0] next_bank_base = {3'h0, next_psw[4:3], 3'h0}; // [RULE4]

	////////////////////////////////////////////////////////////////
	// timer control: hardware sets win over any clear in the same cycle
	wire [7:0] timer_control_w = merge(timer_control, hit_timer_control, w_mask, w_data);
	wire [1:0] pin_fall = pin_q & ~i_ext_irq_pins;
	wire [1:0] trig_edge = {timer_control_w[bbp_pkg::TIMER_CONTROL_IT1],
		timer_control_w[bbp_pkg::TIMER_CONTROL_IT0]}; // [RULE9]
	wire [1:0] ext_ack = {i_irq_ack[bbp_pkg::SRC_EXT1],
		i_irq_ack[bbp_pkg::SRC_EXT0]};
	wire [1:0] tmr_ack = {i_irq_ack[bbp_pkg::SRC_T1],
		i_irq_ack[bbp_pkg::SRC_T0]};
	wire [1:0] old_edge = {timer_control_w[bbp_pkg::TIMER_CONTROL_IE1],
		timer_control_w[bbp_pkg::TIMER_CONTROL_IE0]};
	wire [1:0] old_wrap = {timer_control_w[bbp_pkg::TIMER_CONTROL_TF1],
		timer_control_w[bbp_pkg::TIMER_CONTROL_TF0]};
	// level mode tracks the pin, so servicing cannot clear it
	wire [1:0] next_edge = (trig_edge & ((old_edge & ~ext_ack) | pin_fall)) |
		(~trig_edge & ~i_ext_irq_pins); // [RULE8] [RULE9]
	wire [1:0] next_wrap = (old_wrap & ~tmr_ack) | i_timer_wrap; // [RULE10]
	wire [7:0] next_timer_control = {next_wrap[1], timer_control_w[6], next_wrap[0],
		timer_control_w[4], next_edge[1], timer_control_w[2], next_edge[0], timer_control_w[0]};

	////////////////////////////////////////////////////////////////
	// serial control and receive filter
	wire bbp_pkg::bbp_serial_ctl_type serial_control_w = merge(serial_control, hit_serial_control, w_mask,
		w_data);
	wire rx_take = i_rx_frame && serial_control.rx_enable &&
		!(serial_control.multiproc_filter_bit && !i_rx_ninth); // [RULE12] [RULE13]
	bbp_pkg::bbp_serial_ctl_type next_serial_control;
	always_comb begin
		next_serial_control = serial_control_w;
		if (rx_take) begin
			next_serial_control.rx_ninth_bit = i_rx_ninth;
			next_serial_control.rx_done_flag = 1'b1;
		end
		if (i_tx_done)
			next_serial_control.tx_done_flag = 1'b1;
	end

	////////////////////////////////////////////////////////////////
	// interrupt gating
	wire [7:0] next_ie = merge(ie, hit_ie, w_mask, w_data) &
		bbp_pkg::IE_IMPL; // [RULE25]
	wire [7:0] next_ip = merge(ip, hit_ip, w_mask, w_data) &
		bbp_pkg::IP_IMPL; // [RULE25]
	wire [4:0] pending = {next_serial_control.tx_done_flag | next_serial_control.rx_done_flag,
		next_timer_control[bbp_pkg::TIMER_CONTROL_TF1], next_timer_control[bbp_pkg::TIMER_CONTROL_IE1],
		next_timer_control[bbp_pkg::TIMER_CONTROL_TF0], next_timer_control[bbp_pkg::TIMER_CONTROL_IE0]};
	wire [4:0] next_req = pending & next_ie[4:0] &
		{5{next_ie[bbp_pkg::IE_GLOBAL]}}; // [RULE15] [RULE16]

	// port three: latch drive, strobes pull their pins low
	wire [7:0] next_p3 = merge(p3_latch, hit_p3, w_mask, w_data);
	wire [7:0] strobe_n = ~({i_xmem_rd, i_xmem_wr, 6'h00}); // [RULE7]

	////////////////////////////////////////////////////////////////
	always_comb begin
		case (state)
			bbp_pkg::bbp_idle:
				next_state = take ? bbp_pkg::bbp_fetch : bbp_pkg::bbp_idle;
			bbp_pkg::bbp_fetch:
				next_state = cur_long ? bbp_pkg::bbp_stall :
					bbp_pkg::bbp_commit;
			bbp_pkg::bbp_stall:
				next_state = (stall_cnt == bbp_pkg::STALL_LAST) ?
					bbp_pkg::bbp_commit : bbp_pkg::bbp_stall;
			bbp_pkg::bbp_commit: next_state = bbp_pkg::bbp_idle;
			default: next_state = bbp_pkg::bbp_idle;
		endcase
	end

	bbp_bit_ram u_ram (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_wr_en(ram_wr),
		.i_wr_addr(cur.addr[6:0]),
		.i_wr_data(result),
		.i_rd_addr(i_req.addr[6:0]),
		.o_rd_data(ram_q)
	);

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			state <= bbp_pkg::bbp_idle;
			cur <= '0;
			stall_cnt <= 2'h0;
			operand <= 1'b0;
			o_busy <= 1'b0;
			o_done <= 1'b0;
			o_bit_value <= 1'b0;
		end else begin
			state <= next_state;
			o_busy <= next_state != bbp_pkg::bbp_idle;
			o_done <= commit;
			if (take)
				cur <= i_req;
			if (state == bbp_pkg::bbp_fetch)
				operand <= cur_ram ? ram_q : sfr_bit;
			stall_cnt <= (state == bbp_pkg::bbp_stall) ? stall_cnt + 2'h1 :
				2'h0;
			if (commit)
				o_bit_value <= result;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			program_status_word <= bbp_pkg::PSW_RESET;
			p3_latch <= bbp_pkg::P3_RESET;
			timer_control <= bbp_pkg::TIMER_CONTROL_RESET;
			serial_control <= bbp_pkg::SERIAL_CONTROL_RESET;
			ie <= bbp_pkg::IE_RESET;
			ip <= bbp_pkg::IP_RESET;
			pin_q <= 2'h3;
		end else begin
			program_status_word <= next_psw;
			p3_latch <= next_p3;
			timer_control <= next_timer_control;
			serial_control <= next_serial_control;
			ie <= next_ie;
			ip <= next_ip;
			pin_q <= i_ext_irq_pins;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_sfr_rdata <= 8'h00;
			o_rx_accept <= 1'b0;
			o_port3 <= bbp_pkg::P3_RESET;
			o_status_word <= bbp_pkg::PSW_RESET;
			o_bank_base <= 8'h00;
			o_timer_run <= 2'h0;
			o_serial_ctl <= bbp_pkg::SERIAL_CONTROL_RESET;
			o_irq <= '0;
		end else begin
			if (i_sfr_rd)
				o_sfr_rdata <= sfr_value(sfr_of(i_sfr_addr), program_status_word,
					i_port3_pins, timer_control, serial_control, ie, ip);
			o_rx_accept <= rx_take;
			o_port3 <= next_p3 & strobe_n;
			o_status_word <= next_psw;
			o_bank_base <= next_bank_base;
			o_timer_run <= {next_timer_control[6], next_timer_control[bbp_pkg::TIMER_CONTROL_TR0]}; // [RULE11]
			o_serial_ctl <= next_serial_control; // [RULE14]
			o_irq <= {next_req, next_ip[4:0]}; // [RULE17]
		end
	end

	////////////////////////////////////////////////////////////////
	wire short_take = take && !(i_req.op inside {bbp_pkg::bbp_carry_copy_op,
		bbp_pkg::bbp_carry_and_op, bbp_pkg::bbp_carry_and_not_op,
		bbp_pkg::bbp_carry_or_op, bbp_pkg::bbp_carry_or_not_op,
		bbp_pkg::bbp_no_op});
	wire long_take = take && (i_req.op inside {bbp_pkg::bbp_carry_copy_op,
		bbp_pkg::bbp_carry_and_op, bbp_pkg::bbp_carry_and_not_op,
		bbp_pkg::bbp_carry_or_op, bbp_pkg::bbp_carry_or_not_op});

	sequence short_run_s;
		short_take ##1 !o_done [*2];
	endsequence
	sequence long_run_s;
		long_take ##1 !o_done [*4];
	endsequence

	short_op_time_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE19]
		short_run_s |=> o_done)
		else $error("short bit operation not done in one cycle");
	long_op_time_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE20]
		long_run_s |=> o_done)
		else $error("long bit operation not done in two cycles");
	carry_set_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE19]
		(take && i_req.op == bbp_pkg::bbp_carry_set_op && !i_arith.valid
		&& !i_sfr_wr) ##2 !i_arith.valid |=> o_status_word[7])
		else $error("carry not set by set operation");
	user_flag_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE3]
		!(hit_psw && w_mask[bbp_pkg::PSW_USER]) |=>
		$stable(program_status_word[bbp_pkg::PSW_USER]))
		else $error("user flag changed by hardware");
	parity_even_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE6]
		1'b1 |=>
		(^{$past(i_acc), program_status_word[bbp_pkg::PSW_PARITY]} == 1'b0))
		else $error("parity not even");
	strobe_low_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE7]
		(i_xmem_rd || i_xmem_wr) |=>
		(!o_port3[7] || !$past(i_xmem_rd)) && (!o_port3[6] || !$past(i_xmem_wr)))
		else $error("external memory strobe not low");
	global_gate_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE15]
		!next_ie[bbp_pkg::IE_GLOBAL] |=> o_irq.req == 5'h00)
		else $error("interrupt passed with global enable clear");
	wrap_flag_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE10]
		i_timer_wrap[1] |=> timer_control[bbp_pkg::TIMER_CONTROL_TF1] && (o_irq.req[3] ||
		!ie[3] || !ie[7]))
		else $error("timer wrap flag not set");
	edge_flag_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE8]
		(timer_control_w[bbp_pkg::TIMER_CONTROL_IT0] && pin_fall[0]) |=> timer_control[bbp_pkg::TIMER_CONTROL_IE0])
		else $error("edge flag missed a falling edge");
	rx_filter_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE12]
		(i_rx_frame && serial_control.multiproc_filter_bit && !i_rx_ninth) |=>
		!o_rx_accept)
		else $error("filtered frame accepted");
	reserved_zero_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE25]
		program_status_word[1] == 1'b0 && ie[6:5] == 2'h0 && ip[7:5] == 3'h0)
		else $error("reserved bit holds state");
endmodule

// File: bbp_periph_model.sv
`timescale 1ns/1ps
// stands in for the timer, serial and memory engines
module bbp_periph_model (
	input wire logic i_clk_sys, // core clock
	input wire logic [3:0] i_cmd, // event request
	input wire logic i_ninth, // ninth bit to deliver
	output logic [1:0] o_wrap, // timer overflow pulses
	output logic o_frame, // frame received pulse
	output logic o_ninth, // ninth bit of that frame
	output logic o_xrd // external read strobe
);
	logic [1:0] rd_left;
	initial begin
		o_wrap = 2'h0;
		o_frame = 1'b0;
		o_ninth = 1'b0;
		rd_left = 2'h0;
	end
	always @(posedge i_clk_sys) begin
		o_wrap <= i_cmd[1:0];
		o_frame <= i_cmd[2];
		// outside a frame the ninth bit toggles so stale values never match
		o_ninth <= i_cmd[2] ? i_ninth : !o_ninth;
		rd_left <= i_cmd[3] ? 2'h2 : rd_left - {1'b0, rd_left != 2'h0};
	end
	assign o_xrd = rd_left != 2'h0;
endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
	logic i_clk_sys, i_rst, req_valid, busy, done, bv, swr, srd, cy;
	logic frame, ninth, cninth, accept, xrd, xwr;
	logic [7:0] acc, saddr, swd, rdata, p3pins, p3, program_status_word, bank, r, v;
	logic [7:0] ra [3];
	logic [7:0] rm [3];
	logic [1:0] wrap, pins, run;
	logic [4:0] ack;
	logic [3:0] cmd;
	logic [127:0] ram;
	int n_mismatch, samples_checked, k, seed;
	bbp_pkg::bbp_req_type req;
	bbp_pkg::bbp_arith_type arith;
	bbp_pkg::bbp_serial_ctl_type sctl;
	bbp_pkg::bbp_irq_type irq;
	bbp_core bbp_core_inst (.i_clk_sys, .i_rst, .i_req_valid(req_valid),
		.i_req(req), .o_busy(busy), .o_done(done), .o_bit_value(bv),
		.i_arith(arith), .i_acc(acc), .i_sfr_wr(swr), .i_sfr_rd(srd),
		.i_sfr_addr(saddr), .i_sfr_wdata(swd), .o_sfr_rdata(rdata),
		.i_timer_wrap(wrap), .i_ext_irq_pins(pins), .i_irq_ack(ack),
		.i_tx_done(1'b0), .i_rx_frame(frame), .i_rx_ninth(ninth),
		.o_rx_accept(accept), .i_xmem_rd(xrd), .i_xmem_wr(xwr),
		.i_port3_pins(p3pins), .o_port3(p3), .o_status_word(program_status_word),
		.o_bank_base(bank), .o_timer_run(run), .o_serial_ctl(sctl),
		.o_irq(irq));
	bbp_periph_model bbp_periph_model_inst (.i_clk_sys, .i_cmd(cmd),
		.i_ninth(cninth), .o_wrap(wrap), .o_frame(frame),
		.o_ninth(ninth), .o_xrd(xrd));
	////////////////////////////////////////
	initial begin
		i_clk_sys = 1'b0;
		forever #25 i_clk_sys = !i_clk_sys;
	end
	function automatic logic [7:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	// bench copy of bit ram and carry, updated as each bit ram op is issued
	function automatic logic predict(bbp_pkg::bbp_op_type op, logic [6:0] a);
		logic b;
		b = ram[a];
		case (op)
			bbp_pkg::bbp_carry_set_op: cy = 1'b1;
			bbp_pkg::bbp_carry_clear_op: cy = 1'b0;
			bbp_pkg::bbp_carry_invert_op: cy = !cy;
			bbp_pkg::bbp_bit_set_op: b = 1'b1;
			bbp_pkg::bbp_bit_clear_op: b = 1'b0;
			bbp_pkg::bbp_bit_invert_op: b = !b;
			bbp_pkg::bbp_bit_copy_op: cy = b;
			bbp_pkg::bbp_carry_copy_op: b = cy;
			bbp_pkg::bbp_carry_and_op: cy = cy & b;
			bbp_pkg::bbp_carry_and_not_op: cy = cy & !b;
			bbp_pkg::bbp_carry_or_op: cy = cy | b;
			default: cy = cy | !b;
		endcase
		ram[a] = b;
		return (op inside {4'h4, 4'h5, 4'h6, 4'h8}) ? b : cy;
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic sfr(input logic wr, input logic [7:0] a, d);
		swr = wr;
		srd = !wr;
		saddr = a;
		swd = d;
		@(negedge i_clk_sys);
		swr = 1'b0;
		srd = 1'b0;
		@(negedge i_clk_sys);
	endtask
	task automatic fire(input logic [3:0] c);
		cmd = c;
		@(negedge i_clk_sys);
		cmd = 4'h0;
		repeat (2) @(negedge i_clk_sys);
	endtask
	task automatic bitop(input bbp_pkg::bbp_op_type op, input logic [7:0] a);
		logic e;
		logic [7:0] lat;
		e = a[7] ? 1'b1 : predict(op, a[6:0]);
		lat = op >= bbp_pkg::bbp_carry_copy_op ? 8'h05 : 8'h03;
		req_valid = 1'b1;
		req = '{op, a};
		@(negedge i_clk_sys);
		req_valid = 1'b0;
		check(busy, 1'b1);
		k = 1;
		while (done !== 1'b1 && k < 20) begin
			@(negedge i_clk_sys);
			k++;
		end
		check(8'(k), lat);
		check(busy, 1'b0);
		check(bv, e);
		check(program_status_word[7], cy);
		if (k == 20)
			summarize();
	endtask
	initial begin
		seed = 79487;
		n_mismatch = 0;
		samples_checked = 0;
		ra = '{bbp_pkg::IE_ADDR, bbp_pkg::IP_ADDR, bbp_pkg::SERIAL_CONTROL_ADDR};
		rm = '{bbp_pkg::IE_IMPL, bbp_pkg::IP_IMPL, 8'hF8};
		i_rst = 1'b1;
		req_valid = 1'b0;
		req = '0;
		arith = '0;
		acc = 8'h00;
		swr = 1'b0;
		srd = 1'b0;
		saddr = 8'h00;
		swd = 8'h00;
		pins = 2'h3;
		ack = 5'h00;
		cmd = 4'h0;
		cninth = 1'b0;
		xwr = 1'b0;
		p3pins = 8'hA5;
		ram = '0;
		repeat (12) @(negedge i_clk_sys);
		i_rst = 1'b0;
		check(p3, 8'hFF);
		check(irq, 10'h000);
		// hardware-set serial flags are kept clear in random writes
		for (int i = 0; i < 12; i++) begin
			r = xs() & rm[i % 3];
			sfr(1'b1, ra[i % 3], r);
			sfr(1'b0, ra[i % 3], 8'h00);
			check(rdata, r);
		end
		check(sctl, r);
		$display("register test over");
		for (int i = 0; i < 4; i++) begin
			acc = xs();
			r = xs();
			r[4:3] = 2'(i);
			sfr(1'b1, bbp_pkg::PSW_ADDR, r);
			cy = r[7];
			check(program_status_word, r & 8'hFC | {7'h0, ^acc});
			check(bank, {3'h0, r[4:3], 3'h0});
		end
		for (int i = 0; i < 4; i++) begin
			v = xs();
			arith = {2'h3, v[2:0]};
			@(negedge i_clk_sys);
			arith = '0;
			@(negedge i_clk_sys);
			cy = v[2];
			v = {v[2:1], r[5], 2'h0, v[0], 2'h0};
			check(program_status_word & 8'hE4, v);
		end
		$display("status test over");
		for (int i = 0; i < 48; i++) begin
			v = xs();
			bitop(bbp_pkg::bbp_op_type'(i % 12 + 1), v & 8'h43);
		end
		bitop(bbp_pkg::bbp_bit_set_op, 8'hD5);
		check(program_status_word[5], 1'b1);
		$display("bit op test over");
		sfr(1'b1, bbp_pkg::IE_ADDR, 8'h82);
		fire(4'h1);
		check(irq.req, 5'h02);
		sfr(1'b1, bbp_pkg::IE_ADDR, 8'h02);
		check(irq.req, 5'h00);
		ack = 5'h02;
		@(negedge i_clk_sys);
		ack = 5'h00;
		sfr(1'b1, bbp_pkg::IE_ADDR, 8'h8A);
		check(irq.req, 5'h00);
		fire(4'h2);
		check(irq.req, 5'h08);
		sfr(1'b1, bbp_pkg::IP_ADDR, 8'h15);
		check(irq.high, 5'h15);
		sfr(1'b1, bbp_pkg::TIMER_CONTROL_ADDR, 8'h51);
		check(run, 2'h3);
		pins = 2'h2;
		repeat (2) @(negedge i_clk_sys);
		sfr(1'b0, bbp_pkg::TIMER_CONTROL_ADDR, 8'h00);
		check(rdata & 8'h0B, 8'h03);
		sfr(1'b1, bbp_pkg::TIMER_CONTROL_ADDR, 8'h00);
		check(run, 2'h0);
		sfr(1'b0, bbp_pkg::TIMER_CONTROL_ADDR, 8'h00);
		check(rdata & 8'h0B, 8'h02);
		pins = 2'h3;
		repeat (2) @(negedge i_clk_sys);
		sfr(1'b0, bbp_pkg::TIMER_CONTROL_ADDR, 8'h00);
		check(rdata & 8'h0B, 8'h00);
		$display("interrupt test over");
		for (int i = 0; i < 3; i++) begin
			sfr(1'b1, bbp_pkg::SERIAL_CONTROL_ADDR, i < 2 ? 8'h38 : 8'h08);
			cninth = i != 0;
			cmd = 4'h4;
			k = 0;
			repeat (5) begin
				@(negedge i_clk_sys);
				cmd = 4'h0;
				k += int'(accept === 1'b1);
			end
			check(8'(k), {7'h0, i == 1});
		end
		$display("serial test over");
		cmd = 4'h8;
		xwr = 1'b1;
		@(negedge i_clk_sys);
		cmd = 4'h0;
		xwr = 1'b0;
		check(p3[6], 1'b0);
		@(negedge i_clk_sys);
		check(p3[7], 1'b0);
		// byte reads of port three see the pins, not the latch
		sfr(1'b0, bbp_pkg::P3_ADDR, 8'h00);
		check(rdata, 8'hA5);
		$display("strobe test over");
		summarize();
	end
endmodule
